/* File: rtl/audio_port_defs.vh */
// Purpose: constants for the serial audio port and reset sequencer
// Assumes: 100 MHz system clock
// Notes: times in ns or us; cycle counts derived from them
`ifndef AUDIO_PORT_DEFS_VH
`define AUDIO_PORT_DEFS_VH
`define CLK_PERIOD_NS 10
`define BCLK_MIN_EDGES 7'd32
`define BCLK_MAX_EDGES 7'd64
`define BCLK_RATIO_32 7'd32
`define BCLK_RATIO_48 7'd48
`define BCLK_RATIO_64 7'd64
`define VALID_LOW_NS 300
`define VALID_LOW_CYC (`VALID_LOW_NS / `CLK_PERIOD_NS)
`define CTRL_READY_US 3500
`define CTRL_READY_CYC ((`CTRL_READY_US * 1000) / `CLK_PERIOD_NS)
`define STARTUP_US 10000
`define STARTUP_CYC (((`STARTUP_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEQ_OFF 3'd0
`define SEQ_WAIT_CTRL 3'd1
`define SEQ_IDLE 3'd2
`define SEQ_STARTING 3'd3
`define SEQ_RUN 3'd4
`define SEQ_PWRDN 3'd5
`endif

/* File: rtl/audio_port_reset_sequencer.v */
// Purpose: slave serial audio input port with reset start-up sequencing
// Assumes: bit clock, frame select, data and resets are asynchronous pins
// Notes: bit clock edges found by oversampling with the system clock
// Notes: words come out MSB-aligned; bits past WORD_BITS are dropped
// Notes on behaviour
// - accept 32, 48 or 64 bit edges per frame
// - sample data and frame on rising bit edges
// - reset drops power stage enable after 300 ns
// - start-up takes at least 10 ms after command
// - ignore reset while powered down
// - frame low left word, high right word
// - data one bit late, MSB first, trailing masked
// - ratio must be exactly 32, 48 or 64
`timescale 1ns/1ps
`include "audio_port_defs.vh"

module audio_port_reset_sequencer #(
	parameter WORD_BITS = 24,
	parameter CTRL_READY_CYCLES = `CTRL_READY_CYC,
	parameter STARTUP_CYCLES = `STARTUP_CYC
) (
	input wire clk,
	input wire sys_rst,
	input wire bit_clk,
	input wire frame_sel,
	input wire serial_audio_in,
	input wire reset_n,
	input wire power_down_n,
	input wire startup_cmd,
	output reg power_stage_en,
	output reg ctrl_ready,
	output reg running,
	output reg [WORD_BITS-1:0] left_word,
	output reg [WORD_BITS-1:0] right_word,
	output reg word_valid,
	output reg ratio_ok,
	output reg [6:0] ratio
);

// ======================================================================
// constants
// kept as a plain integer so the counter load can take its low bits on purpose
localparam integer VALID_LOW_CYCLES = `VALID_LOW_CYC;

// ======================================================================
// input synchronisers
// every pin but startup_cmd and sys_rst passes two flops; a bit clock edge shows three clocks late,
// so the bit clock needs at least four system clocks per period
reg [1:0] bclk_s, fs_s, sd_s, rst_s, pdn_s;
reg bclk_d;
always @(posedge clk) begin
	if (sys_rst) begin
		bclk_s <= 2'h0;
		fs_s <= 2'h0;
		sd_s <= 2'h0;
		rst_s <= 2'h0;
		pdn_s <= 2'h0;
		bclk_d <= 1'b0;
	end else begin
		bclk_s <= {bclk_s[0], bit_clk};
		fs_s <= {fs_s[0], frame_sel};
		sd_s <= {sd_s[0], serial_audio_in};
		rst_s <= {rst_s[0], reset_n};
		pdn_s <= {pdn_s[0], power_down_n};
		bclk_d <= bclk_s[1];
	end
end
// detector state resets low like the idle pin, so no false edge after reset
wire bclk_rise = bclk_s[1] & ~bclk_d;

// ======================================================================
// serial capture
reg fs_prev_reg;
reg [6:0] edge_cnt_reg;
reg [6:0] bit_idx_reg;
reg [WORD_BITS-1:0] shift_reg;
reg first_reg;
wire fs_now = fs_s[1];
wire fs_change = bclk_rise & (fs_now != fs_prev_reg);
wire fs_risen = fs_change & fs_now;
// ratio counts rising bit edges from one frame rise to the next
wire ratio_good = (edge_cnt_reg == `BCLK_RATIO_32) | (edge_cnt_reg == `BCLK_RATIO_48) |
	(edge_cnt_reg == `BCLK_RATIO_64);
// each bit is placed by its index below the MSB, so short words come out
// MSB-aligned and bits past the word width fall off
wire [WORD_BITS-1:0] bit_pos = (bit_idx_reg < WORD_BITS) ?
	({{(WORD_BITS-1){1'b0}}, 1'b1} << (WORD_BITS - 1 - bit_idx_reg)) :
	{WORD_BITS{1'b0}};
wire [WORD_BITS-1:0] shift_next = sd_s[1] ? (shift_reg | bit_pos) : shift_reg;

always @(posedge clk) begin
	if (sys_rst) begin
		fs_prev_reg <= 1'b0;
		edge_cnt_reg <= 7'h00;
		bit_idx_reg <= 7'h00;
		shift_reg <= {WORD_BITS{1'b0}};
		first_reg <= 1'b1;
		left_word <= {WORD_BITS{1'b0}};
		right_word <= {WORD_BITS{1'b0}};
		word_valid <= 1'b0;
		ratio_ok <= 1'b0;
		ratio <= 7'h00;
	end else begin
		word_valid <= 1'b0;
		if (bclk_rise) begin
			fs_prev_reg <= fs_now;
			if (fs_risen) begin
				edge_cnt_reg <= 7'h01;
				if (!first_reg) begin
					ratio <= edge_cnt_reg;
					ratio_ok <= ratio_good;
				end
				first_reg <= 1'b0;
			end else if (edge_cnt_reg < `BCLK_MAX_EDGES + 7'd1) begin
				edge_cnt_reg <= edge_cnt_reg + 7'd1;
			end else begin
				ratio_ok <= 1'b0;
			end
			if (fs_change) begin
				// the bit under a frame edge is the last of the word now ended;
				// the next word's MSB follows one bit later
				bit_idx_reg <= 7'h00;
				shift_reg <= {WORD_BITS{1'b0}};
				if (fs_now) begin
					left_word <= shift_next;
				end else begin
					// a pair completes on the right word; only good frames flag it
					right_word <= shift_next;
					word_valid <= ratio_ok;
				end
			end else begin
				shift_reg <= shift_next;
				if (bit_idx_reg < 7'h7F)
					bit_idx_reg <= bit_idx_reg + 7'd1;
			end
		end
	end
end

// ======================================================================
// reset and start-up sequencer
reg [2:0] state_reg;
reg [20:0] cnt_reg;
reg rst_prev_reg;
wire rst_fall = rst_prev_reg & ~rst_s[1];
always @(posedge clk) begin
	if (sys_rst) begin
		state_reg <= `SEQ_OFF;
		cnt_reg <= 21'h0;
		rst_prev_reg <= 1'b0;
		power_stage_en <= 1'b0;
		ctrl_ready <= 1'b0;
		running <= 1'b0;
	end else begin
		rst_prev_reg <= rst_s[1];
		if (cnt_reg != 21'h0)
			cnt_reg <= cnt_reg - 21'd1;
		// OFF, WAIT_CTRL, IDLE, STARTING, RUN; RUN and PWRDN swap on the pin
		case (state_reg)
		`SEQ_OFF: begin
			ctrl_ready <= 1'b0;
			running <= 1'b0;
			// delay the drop of the power stage enable
			if (cnt_reg == 21'h0)
				power_stage_en <= 1'b0;
			// leave only after the enable drop has gone out, even on a short pulse
			if (rst_s[1] && pdn_s[1] && cnt_reg == 21'h0) begin
				state_reg <= `SEQ_WAIT_CTRL;
				cnt_reg <= CTRL_READY_CYCLES[20:0];
			end
		end
		`SEQ_WAIT_CTRL: begin
			// control port stays closed until the count runs out
			if (cnt_reg == 21'h0) begin
				ctrl_ready <= 1'b1;
				state_reg <= `SEQ_IDLE;
			end
		end
		`SEQ_IDLE: begin
			if (startup_cmd) begin
				state_reg <= `SEQ_STARTING;
				cnt_reg <= STARTUP_CYCLES[20:0];
			end
		end
		`SEQ_STARTING: begin
			// stage and running flag come up together
			if (cnt_reg == 21'h0) begin
				power_stage_en <= 1'b1;
				running <= 1'b1;
				state_reg <= `SEQ_RUN;
			end
		end
		`SEQ_RUN: begin
			if (!pdn_s[1]) begin
				running <= 1'b0;
				power_stage_en <= 1'b0;
				state_reg <= `SEQ_PWRDN;
			end
		end
		`SEQ_PWRDN: begin
			// reset is not acted on while powered down
			if (pdn_s[1])
				state_reg <= `SEQ_RUN;
			if (pdn_s[1])
				running <= 1'b1;
			if (pdn_s[1])
				power_stage_en <= 1'b1;
		end
		default: state_reg <= `SEQ_OFF;
		endcase
		// a reset edge while the power-down pin is held is dropped for good,
		// so a later release of power down resumes where it left off
		if (rst_fall && pdn_s[1] && state_reg != `SEQ_PWRDN &&
			state_reg != `SEQ_OFF) begin
			state_reg <= `SEQ_OFF;
			cnt_reg <= VALID_LOW_CYCLES[20:0];
			ctrl_ready <= 1'b0;
			running <= 1'b0;
		end
	end
end

endmodule

/* File: tb/seq_port_props.sv */
// Purpose: port checks. Assumes: top ports. Notes: bounds cover sync lag
`timescale 1ns/1ps
module seq_port_props(
	input wire clk,
	input wire sys_rst,
	input wire reset_n,
	input wire power_down_n,
	input wire startup_cmd,
	input wire power_stage_en,
	input wire ctrl_ready,
	input wire running,
	input wire word_valid,
	input wire ratio_ok,
	input wire [6:0] ratio
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_valid_ok: assert property (word_valid |-> ratio_ok) else $error("bad valid");
	chk_ratio_set: assert property (ratio_ok |-> ratio inside {7'h20, 7'h30, 7'h40})
		else $error("bad ratio");
	chk_run_ready: assert property (running |-> ctrl_ready) else $error("run early");
	chk_stage_run: assert property ($rose(power_stage_en) |-> $rose(running))
		else $error("stage on");
	chk_start_wait: assert property ($rose(startup_cmd) && !running |=> !running [*8])
		else $error("fast start");
	chk_reset_drop: assert property ($fell(reset_n) |-> ##[1:40] !power_stage_en)
		else $error("stage kept");
	chk_reset_hold: assert property ((!reset_n && power_down_n) [*8] |-> !ctrl_ready)
		else $error("ready in reset");
	chk_pdn_off: assert property (!power_down_n [*6] |-> !power_stage_en)
		else $error("on in power down");
endmodule

/* File: tb/audio_src_model.sv */
// Purpose: serial source. Assumes: 80 ns bit clock. Notes: clock halts when idle
`timescale 1ns/1ps
module audio_src_model(
	input wire en,
	input wire [6:0] n,
	input wire [23:0] lw,
	input wire [23:0] rw,
	output reg bit_clk,
	output reg frame_sel,
	output reg serial_audio_in
);
	integer i;
	integer j;
	initial begin
		{bit_clk, frame_sel, serial_audio_in} = 3'h2;
		forever begin
			if (en !== 1'b1 || n < 7'd2) begin
				#40;
				serial_audio_in = ~serial_audio_in;
			end else for (i = 0; i < n; i = i + 1) begin
				j = i % (n / 2);
				bit_clk = 1'b0;
				frame_sel = i >= n / 2;
				// the slot under a frame edge carries the last bit of the word before
				if (j > 0 && j < 25)
					serial_audio_in = frame_sel ? rw[24-j] : lw[24-j];
				else if (j == 0 && n / 2 < 25)
					serial_audio_in = frame_sel ? lw[24-n/2] : rw[24-n/2];
				else
					serial_audio_in = 1'b0;
				#40 bit_clk = 1'b1;
				#40;
			end
		end
	end
endmodule

/* File: tb/audio_port_reset_sequencer_tb.sv */
// Purpose: bench. Assumes: short counts. Notes: rows hold ratio, words, mask
`timescale 1ns/1ps
module audio_port_reset_sequencer_tb;
	logic clk, sys_rst, reset_n, power_down_n, startup_cmd, en, bit_clk, frame_sel;
	logic serial_audio_in, power_stage_en, ctrl_ready, running, word_valid, ratio_ok;
	logic [6:0] ratio, n;
	logic [23:0] left_word, right_word, lw, rw, m;
	logic [78:0] rows [3];
	int fail_count = 0;
	int checks_done = 0;
	wire [2:0] flags = {word_valid, running, ctrl_ready};
	audio_port_reset_sequencer #(.CTRL_READY_CYCLES(20), .STARTUP_CYCLES(30)) u_dut(
		.clk(clk), .sys_rst(sys_rst), .bit_clk(bit_clk), .frame_sel(frame_sel),
		.serial_audio_in(serial_audio_in), .reset_n(reset_n), .power_down_n(power_down_n),
		.startup_cmd(startup_cmd), .power_stage_en(power_stage_en), .ctrl_ready(ctrl_ready),
		.running(running), .left_word(left_word), .right_word(right_word),
		.word_valid(word_valid), .ratio_ok(ratio_ok), .ratio(ratio));
	audio_src_model u_src(.en(en), .n(n), .lw(lw), .rw(rw), .bit_clk(bit_clk),
		.frame_sel(frame_sel), .serial_audio_in(serial_audio_in));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task cyc(input int c);
		repeat (c) @(posedge clk) #1;
	endtask
	task cmp(input logic [23:0] g, input logic [23:0] e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task summarize;
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wt(input int s, input int lim);
		int i;
		for (i = 0; i < lim && flags[s] !== 1'b1; i++)
			cyc(1);
		if (i == lim) begin
			fail_count++;
			summarize;
		end
	endtask
	initial begin
		{sys_rst, reset_n, power_down_n, startup_cmd, en, n, lw, rw} = {5'h14, 55'h0};
		rows = '{{7'h20, 24'hA5C3F1, 24'h5A3C0E, 24'hFFFF00},
			{7'h30, 24'h81F00F, 24'h7E0FF1, 24'hFFFFFF},
			{7'h40, 24'hC0FFEE, 24'h3B1D5A, 24'hFFFFFF}};
		cyc(12);
		sys_rst = 0;
		cyc(5);
		reset_n = 1;
		cyc(15);
		cmp(ctrl_ready, 0);
		wt(0, 30);
		startup_cmd = 1;
		cyc(1);
		startup_cmd = 0;
		cyc(20);
		cmp(running, 0);
		wt(1, 30);
		en = 1;
		foreach (rows[r]) begin
			{n, lw, rw, m} = rows[r];
			cyc(1600);
			wt(2, 700);
			cmp(ratio, n);
			cmp(ratio_ok, 1);
			cmp(left_word, lw & m);
			cmp(right_word, rw & m);
		end
		power_down_n = 0;
		cyc(6);
		cmp(running, 0);
		cmp(power_stage_en, 0);
		reset_n = 0;
		cyc(10);
		reset_n = 1;
		cyc(2);
		power_down_n = 1;
		cyc(5);
		cmp(running, 1);
		cmp(power_stage_en, 1);
		reset_n = 0;
		cyc(10);
		cmp(power_stage_en, 1);
		cyc(30);
		cmp(power_stage_en, 0);
		cmp(ctrl_ready, 0);
		reset_n = 1;
		wt(0, 40);
		power_down_n = 0;
		cyc(10);
		reset_n = 0;
		cyc(10);
		reset_n = 1;
		cyc(2);
		power_down_n = 1;
		cyc(2);
		cmp(ctrl_ready, 1);
		summarize;
	end
endmodule
bind audio_port_reset_sequencer seq_port_props u_props(.clk(clk), .sys_rst(sys_rst),
	.reset_n(reset_n), .power_down_n(power_down_n), .startup_cmd(startup_cmd),
	.power_stage_en(power_stage_en), .ctrl_ready(ctrl_ready), .running(running),
	.word_valid(word_valid), .ratio_ok(ratio_ok), .ratio(ratio));
